/* src/swp_pkg.sv */
// Purpose: shared constants for the sleep and wake power manager
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   register offsets below are byte addresses, bits are bit positions
package swp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00; // control word
  localparam logic [7:0] OFS_WDOG     = 8'h04; // watchdog enable and restart
  localparam logic [7:0] OFS_STCFG    = 8'h08; // sleep timer configuration
  localparam logic [7:0] OFS_STCNT    = 8'h0C; // sleep timer count, read only
  localparam logic [7:0] OFS_CMPA     = 8'h10; // compare A value
  localparam logic [7:0] OFS_CMPB     = 8'h14; // compare B value
  localparam logic [7:0] OFS_WAKEREC  = 8'h18; // wake record, write one to clear
  localparam logic [7:0] OFS_PERIDIS  = 8'h1C; // peripheral disable
  localparam logic [7:0] OFS_WAKECORE = 8'h20; // core wake bit
  localparam logic [7:0] OFS_STATUS   = 8'h24; // power state
  // control word bits
  localparam int CTRL_DS2    = 0; // deep sleep 2 selected
  localparam int CTRL_RCOFF  = 1; // rc oscillator stops in deep sleep 1 and 2
  localparam int CTRL_EVTCLK = 2; // event timer on sleep timer clock
  // sleep timer config bits
  localparam int STC_SRC   = 0;  // 1: watch crystal
  localparam int STC_PAUSE = 1;  // pause on debug halt
  localparam int STC_IEA   = 2;  // compare A enable
  localparam int STC_IEB   = 3;  // compare B enable
  localparam int STC_IEW   = 4;  // wrap enable
  localparam int STC_EXP   = 8;  // prescaler exponent, 4 bits
  localparam logic [3:0] STC_EXP_RST = 4'h1;
  // peripheral disable bits
  localparam int PD_SC1  = 1;
  localparam int PD_RSVD = 5;
  // wake record bits
  localparam int WK_GPIO = 0;
  localparam int WK_PTB2 = 1;
  localparam int WK_IRQ  = 2;
  localparam int WK_DBG  = 3;
  localparam int WK_SYS  = 4;
  localparam int WK_CMPA = 5;
  localparam int WK_CMPB = 6;
  localparam int WK_WRAP = 7;
  localparam int WK_CORE = 8;
  localparam int WK_N    = 9;
  // watchdog timing in ms of the 1 kHz reference
  localparam int WDOG_TIMEOUT_MS = 2048;
  localparam int WDOG_WARN_MS    = 1792;
  localparam logic [11:0] WDOG_TIMEOUT = 12'(WDOG_TIMEOUT_MS);
  localparam logic [11:0] WDOG_WARN    = 12'(WDOG_WARN_MS);
  // core reset pulse length after deep sleep
  localparam logic [3:0] CORE_RST_CYC = 4'h8;
  // power states
  typedef enum logic [2:0] {
    PS_RUN   = 3'b000,
    PS_IDLE  = 3'b001,
    PS_PRE   = 3'b010,
    PS_DS0   = 3'b011,
    PS_DS12  = 3'b100,
    PS_RESET = 3'b101
  } swp_state_t;
endpackage : swp_pkg

/* src/swp_power_manager.sv */
// Purpose: sleep modes, wake sources, watchdog, sleep timer, clock gate
// Assumes: slow clocks and pins arrive as levels sampled on hclk
// Notes:   timers advance on synchronised edges of their slow clocks
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
module swp_power_manager (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        calibrated_khz_reference,
  input  wire logic        watch_crystal_clock,
  input  wire logic        crystal_in_use,
  input  wire logic        wfi,
  input  wire logic        sleep_deep,
  input  wire logic        irq_any,
  input  wire logic        debug_halt,
  input  wire logic        dbg_pwrup_req,
  input  wire logic        sys_pwrup_req,
  input  wire logic [15:0] gpio_in,
  input  wire logic        routable_external_irq,
  output logic             core_sleeping,
  output logic             core_power_on,
  output logic             core_reset_n,
  output logic             periph_reset_n,
  output logic             low_freq_rc_oscillator_on,
  output logic             wdog_nmi,
  output logic             wdog_reset,
  output logic             stimer_irq,
  output logic             event_timer_tick,
  output logic             sc1_clk_en
);
  localparam int PTB2_IDX = 10;            // port b bit two within gpio_in
  localparam int WK_N_L   = swp_pkg::WK_N; // wake record width
  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] hrdata;         // read data
    logic        hreadyout;      // always ready
    logic        ph_act;         // pending data phase, read or write
    logic        ph_wr;          // pending is a write
    logic [7:0]  ph_ofs;         // pending offset
    logic [1:0]  s_khz;          // reference synchroniser
    logic [1:0]  s_xtl;          // crystal synchroniser
    logic [18:0] s_pin1;         // pin synchroniser first stage
    logic [18:0] s_pin2;         // pin synchroniser second stage
    logic        khz_d;          // reference delayed
    logic        xtl_d;          // crystal delayed
    logic [15:0] gpio_d;         // gpio delayed
    logic        ptb2_d;         // port b bit two delayed
    logic        irq_d;          // external irq delayed
    logic        dbg_d;          // debug request delayed
    logic        sys_d;          // system request delayed
    logic [2:0]  ctrl;           // control word
    logic        wd_en;          // watchdog enabled
    logic [11:0] wd_cnt;         // watchdog ms count
    logic [15:0] stcfg;          // sleep timer config
    logic [15:0] pre;            // prescaler counter
    logic [31:0] st_cnt;         // sleep timer count
    logic [31:0] cmpa;           // compare A value
    logic [31:0] cmpb;           // compare B value
    logic [WK_N_L-1:0] wake_rec; // wake record
    logic [5:0]  peridis;        // peripheral disable
    logic        wake_core;      // core wake bit
    logic [3:0]  rst_cnt;        // core reset counter
    swp_pkg::swp_state_t st;     // power state
    logic        o_sleep;        // core halted
    logic        o_pwr;          // core powered
    logic        o_crst_n;       // core reset
    logic        o_prst_n;       // peripheral reset
    logic        o_rc;           // rc oscillator running
    logic        o_nmi;          // watchdog warning
    logic        o_wdrst;        // watchdog expiry
    logic        o_stirq;        // sleep timer interrupt
    logic        o_evt;          // event timer tick
    logic        o_sc1;          // sc1 clock enable
  } swp_regs_t;
  swp_regs_t r, n; // registered state and next
  ////////////////////////////////////////////////////////////////////
  // slow clock edges, timer gating and wake source events
  logic        khz_s, xtl_s, dbg_s, sys_s, irq_s, ptb2_s;
  logic [15:0] gpio_s;
  logic        khz_rise, xtl_rise, src_rise, tick, timers_run, ds1;
  logic        hit_a, hit_b, hit_w;
  logic [WK_N_L-1:0] ev;
  logic [31:0] rd;
  logic [3:0]  ex;
  always_comb begin
    khz_s    = r.s_khz[1];
    xtl_s    = r.s_xtl[1];
    gpio_s   = r.s_pin2[15:0];
    ptb2_s   = r.s_pin2[PTB2_IDX];
    irq_s    = r.s_pin2[16];
    dbg_s    = r.s_pin2[17];
    sys_s    = r.s_pin2[18];
    khz_rise = khz_s & ~r.khz_d;
    xtl_rise = xtl_s & ~r.xtl_d;
    ds1      = ~r.ctrl[swp_pkg::CTRL_DS2];
    // rc off in deep sleep without crystal freezes both timers
    timers_run = r.o_rc | crystal_in_use;
    // clock source: reference after reset, crystal when chosen
    src_rise = r.stcfg[swp_pkg::STC_SRC] ? xtl_rise : (khz_rise & r.o_rc);
    ex   = r.stcfg[swp_pkg::STC_EXP +: 4];
    // divide by two to the exponent
    tick = src_rise & timers_run & (r.pre == ((16'h0001 << ex) - 16'h0001))
           & ~(r.stcfg[swp_pkg::STC_PAUSE] & debug_halt);
    hit_a = tick & (r.st_cnt + 32'h1 == r.cmpa);
    hit_b = tick & (r.st_cnt + 32'h1 == r.cmpb);
    hit_w = tick & (r.st_cnt == 32'hFFFF_FFFF);
    ev = '0;
    ev[swp_pkg::WK_GPIO] = |(gpio_s ^ r.gpio_d);
    ev[swp_pkg::WK_PTB2] = ptb2_s ^ r.ptb2_d;
    ev[swp_pkg::WK_IRQ]  = irq_s ^ r.irq_d;
    ev[swp_pkg::WK_DBG]  = dbg_s & ~r.dbg_d;
    ev[swp_pkg::WK_SYS]  = sys_s & ~r.sys_d;
    ev[swp_pkg::WK_CMPA] = hit_a & r.stcfg[swp_pkg::STC_IEA];
    ev[swp_pkg::WK_CMPB] = hit_b & r.stcfg[swp_pkg::STC_IEB];
    ev[swp_pkg::WK_WRAP] = hit_w & r.stcfg[swp_pkg::STC_IEW];
    ev[swp_pkg::WK_CORE] = r.wake_core;
  end
  ////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd = 32'h0000_0000;
    unique case (r.ph_ofs)
      swp_pkg::OFS_CTRL:     rd[2:0] = r.ctrl;
      swp_pkg::OFS_WDOG:     rd = {19'h0, r.wd_cnt, r.wd_en};
      swp_pkg::OFS_STCFG:    rd[15:0] = r.stcfg;
      swp_pkg::OFS_STCNT:    rd = r.st_cnt;
      swp_pkg::OFS_CMPA:     rd = r.cmpa;
      swp_pkg::OFS_CMPB:     rd = r.cmpb;
      swp_pkg::OFS_WAKEREC:  rd[WK_N_L-1:0] = r.wake_rec;
      swp_pkg::OFS_PERIDIS:  rd[5:0] = r.peridis;
      swp_pkg::OFS_WAKECORE: rd[0] = r.wake_core;
      swp_pkg::OFS_STATUS:   rd[2:0] = r.st;
      default:               rd = 32'h0000_0000; // unmapped reads zero
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = r;
    n.s_khz  = {r.s_khz[0], calibrated_khz_reference};
    n.s_xtl  = {r.s_xtl[0], watch_crystal_clock};
    n.s_pin1 = {sys_pwrup_req, dbg_pwrup_req, routable_external_irq, gpio_in};
    n.s_pin2 = r.s_pin1; // only the second stage feeds logic
    n.khz_d  = khz_s;
    n.xtl_d  = xtl_s;
    n.gpio_d = gpio_s;
    n.ptb2_d = ptb2_s;
    n.irq_d  = irq_s;
    n.dbg_d  = dbg_s;
    n.sys_d  = sys_s;
    n.o_nmi   = 1'b0;
    n.o_wdrst = 1'b0;
    n.o_stirq = 1'b0;
    // event timer: core clock each cycle or sleep timer tick
    n.o_evt = r.ctrl[swp_pkg::CTRL_EVTCLK] ? tick : 1'b1;
    // watchdog counts ms of reference, held while halted
    if (r.wd_en & khz_rise & timers_run & ~debug_halt) begin
      n.wd_cnt = r.wd_cnt + 12'h001;
      if (r.wd_cnt + 12'h001 == swp_pkg::WDOG_WARN) n.o_nmi = 1'b1;
      if (r.wd_cnt + 12'h001 == swp_pkg::WDOG_TIMEOUT) begin
        n.o_wdrst = 1'b1;
        n.wd_cnt  = 12'h000;
      end
    end
    // prescaler and counter
    if (src_rise & timers_run & ~(r.stcfg[swp_pkg::STC_PAUSE] & debug_halt)) begin
      n.pre = tick ? 16'h0000 : r.pre + 16'h0001;
    end
    if (tick) n.st_cnt = r.st_cnt + 32'h1;
    n.o_stirq = |ev[swp_pkg::WK_WRAP:swp_pkg::WK_CMPA];
    // bus address phase
    n.hreadyout = 1'b1;
    n.ph_act = hsel & hready & htrans[1];
    n.ph_wr  = hwrite;
    n.ph_ofs = haddr[7:0];
    if (hsel & hready & htrans[1] & ~hwrite) n.hrdata = 32'h0; // filled below
    if (r.ph_act & ~r.ph_wr) n.hrdata = rd;
    // wake record: set wins over clear
    if (r.ph_act & r.ph_wr & r.ph_ofs == swp_pkg::OFS_WAKEREC) begin
      n.wake_rec = r.wake_rec & ~hwdata[WK_N_L-1:0];
    end
    n.wake_rec = n.wake_rec | ev;
    // register writes
    if (r.ph_act & r.ph_wr) begin
      unique case (r.ph_ofs)
        swp_pkg::OFS_CTRL:  n.ctrl = hwdata[2:0];
        swp_pkg::OFS_WDOG: begin
          n.wd_en = hwdata[0];
          if (hwdata[1]) n.wd_cnt = 12'h000; // restart, kept by software
        end
        swp_pkg::OFS_STCFG: begin
          n.stcfg = hwdata[15:0];
          n.pre   = 16'h0000;
        end
        swp_pkg::OFS_CMPA:     n.cmpa = hwdata;
        swp_pkg::OFS_CMPB:     n.cmpb = hwdata;
        swp_pkg::OFS_PERIDIS:  n.peridis = hwdata[5:0] & 6'h22;
        swp_pkg::OFS_WAKECORE: n.wake_core = hwdata[0];
        default: ;
      endcase
    end
    // sc1 clock off while disabled; its registers freeze with the clock
    n.o_sc1 = ~r.peridis[swp_pkg::PD_SC1];
    // power state machine
    unique case (r.st)
      swp_pkg::PS_RUN: begin
        if (wfi & ~sleep_deep) begin
          n.st = swp_pkg::PS_IDLE;
          n.o_sleep = 1'b1;
        end else if (wfi & sleep_deep) begin
          n.st = swp_pkg::PS_PRE;
          n.o_sleep = 1'b1;
        end
      end
      swp_pkg::PS_IDLE: begin
        if (irq_any) begin
          n.st = swp_pkg::PS_RUN;
          n.o_sleep = 1'b0;
        end
      end
      swp_pkg::PS_PRE: begin
        if (~sys_s) begin
          n.wake_core = 1'b0;
          if (dbg_s) begin // connected debugger keeps core powered
            n.st = swp_pkg::PS_DS0;
            n.o_prst_n = 1'b0;
          end else begin
            n.st = swp_pkg::PS_DS12;
            n.o_pwr = 1'b0;
            n.o_crst_n = 1'b0;
            n.o_prst_n = 1'b0;
            if (r.ctrl[swp_pkg::CTRL_RCOFF] | r.ctrl[swp_pkg::CTRL_DS2]) n.o_rc = 1'b0;
          end
        end
      end
      swp_pkg::PS_DS0: begin
        if (|ev[swp_pkg::WK_SYS:swp_pkg::WK_GPIO] | ev[swp_pkg::WK_CORE]) begin
          n.st = swp_pkg::PS_RESET;
          n.o_crst_n = 1'b0;
          n.wake_core = 1'b0; // consumed, so it is not recorded forever
          n.rst_cnt = swp_pkg::CORE_RST_CYC;
        end
      end
      swp_pkg::PS_DS12: begin
        if (|ev[swp_pkg::WK_SYS:swp_pkg::WK_GPIO]
            | (ds1 & |ev[swp_pkg::WK_WRAP:swp_pkg::WK_CMPA])) begin
          n.st = swp_pkg::PS_RESET;
          n.o_pwr = 1'b1;
          n.o_rc  = 1'b1;
          n.rst_cnt = swp_pkg::CORE_RST_CYC;
        end
      end
      swp_pkg::PS_RESET: begin
        n.rst_cnt = r.rst_cnt - 4'h1;
        if (r.rst_cnt == 4'h1) begin
          n.st = swp_pkg::PS_RUN;
          n.o_crst_n = 1'b1;
          n.o_prst_n = 1'b1;
          n.o_sleep = 1'b0;
        end
      end
      default: n.st = swp_pkg::PS_RUN;
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.stcfg     <= {4'h0, swp_pkg::STC_EXP_RST, 8'h00};
      r.st        <= swp_pkg::PS_RUN;
      r.o_pwr     <= 1'b1;
      r.o_crst_n  <= 1'b1;
      r.o_prst_n  <= 1'b1;
      r.o_rc      <= 1'b1;
      r.o_evt     <= 1'b1;
      r.o_sc1     <= 1'b1;
    end else begin
      r <= n;
    end
  end
  // outputs straight from flip-flops, hresp tied low
  assign hrdata                    = r.hrdata;
  assign hreadyout                 = r.hreadyout;
  assign hresp                     = 1'b0;
  assign core_sleeping             = r.o_sleep;
  assign core_power_on             = r.o_pwr;
  assign core_reset_n              = r.o_crst_n;
  assign periph_reset_n            = r.o_prst_n;
  assign low_freq_rc_oscillator_on = r.o_rc;
  assign wdog_nmi                  = r.o_nmi;
  assign wdog_reset                = r.o_wdrst;
  assign stimer_irq                = r.o_stirq;
  assign event_timer_tick          = r.o_evt;
  assign sc1_clk_en                = r.o_sc1;
endmodule // swp_power_manager

/* verif/swp_core_model.sv */
// Purpose: core and debug port stand-in for sleep requests
// Assumes: requests from the bench change just after rising edges
// Notes:   debug requests stay up until the bench drops them
module swp_core_model (
  input  wire logic hclk,
  input  wire logic go,
  input  wire logic deep,
  input  wire logic dbg_on,
  input  wire logic sys_on,
  output logic      wfi,
  output logic      sleep_deep,
  output logic      dbg_pwrup_req,
  output logic      sys_pwrup_req
);
  // all quiet at time zero
  initial {wfi, sleep_deep, dbg_pwrup_req, sys_pwrup_req} = 4'h0;
  // one wfi per request, deep flag beside it
  always @(posedge hclk) begin
    wfi           <= go;
    sleep_deep    <= deep;
    dbg_pwrup_req <= dbg_on;
    sys_pwrup_req <= sys_on;
  end
endmodule // swp_core_model

/* verif/swp_power_manager_monitor.sv */
// Purpose: port checker for the sleep and wake power manager
// Assumes: one hclk domain, hresetn async active low
// Notes:   counts reference edges itself to time the watchdog
module swp_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        calibrated_khz_reference,
  input wire logic        wfi,
  input wire logic        sleep_deep,
  input wire logic        sys_pwrup_req,
  input wire logic        core_sleeping,
  input wire logic        core_power_on,
  input wire logic        core_reset_n,
  input wire logic        periph_reset_n,
  input wire logic        wdog_nmi,
  input wire logic        wdog_reset,
  input wire logic        sc1_clk_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        ref_q;   // last reference level
  logic [15:0] ref_all; // reference edges since reset
  logic [15:0] ref_nmi; // reference edges since warning
  logic        pd_wr;   // data phase of a disable write
  //////////////////////////////////////////////////////////////////
  // edge counters and write tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_q   <= 1'b0;
      ref_all <= 16'h0000;
      ref_nmi <= 16'h0000;
      pd_wr   <= 1'b0;
    end else begin
      ref_q   <= calibrated_khz_reference;
      ref_all <= ref_all + 16'(calibrated_khz_reference & ~ref_q);
      ref_nmi <= wdog_nmi ? 16'h0000 : ref_nmi + 16'(calibrated_khz_reference & ~ref_q);
      pd_wr   <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == swp_pkg::OFS_PERIDIS);
    end
  end
  //////////////////////////////////////////////////////////////////
  // debugger busy, then core wake reset
  sequence s_sys_held; sys_pwrup_req [*6]; endsequence
  sequence s_core_rst; !core_reset_n [*7] ##[1:3] core_reset_n; endsequence
  AST_WDOG_OFF: assert property (wdog_nmi |-> ref_all >= 16'h06FE)
    else $error("watchdog warning came too early after reset");
  AST_WARN_GAP: assert property (wdog_reset |-> ref_nmi inside {[16'h00FE:16'h0102]})
    else $error("watchdog expiry not 256 edges after warning");
  AST_NMI_PULSE: assert property (wdog_nmi |=> !wdog_nmi)
    else $error("warning pulse longer than one cycle");
  AST_PRE_HOLD: assert property (s_sys_held |-> !$fell(core_power_on) && !$fell(periph_reset_n))
    else $error("power down while debugger still busy");
  AST_OFF_RESET: assert property (!core_power_on |-> !core_reset_n)
    else $error("core unpowered but out of reset");
  AST_WAKE_RST: assert property ($rose(core_power_on) |-> s_core_rst)
    else $error("core reset after wake has wrong length");
  AST_SC1_WRITE: assert property ($changed(sc1_clk_en) |-> $past(pd_wr) || $past(pd_wr, 2))
    else $error("clock gate moved without a disable write");
  AST_IDLE_ENTER: assert property (wfi && !sleep_deep && !core_sleeping && core_reset_n
    |-> ##[1:2] core_sleeping)
    else $error("idle sleep not entered after wfi");
endmodule // swp_monitor

bind swp_power_manager swp_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .calibrated_khz_reference, .wfi, .sleep_deep, .sys_pwrup_req, .core_sleeping,
  .core_power_on, .core_reset_n, .periph_reset_n, .wdog_nmi, .wdog_reset, .sc1_clk_en);

/* verif/test_sleep_wake_power_manager.sv */
// Purpose: self-checking bench for the sleep and wake power manager
// Assumes: zero-wait bus, reference clock of 16 hclk cycles
// Notes:   watchdog part runs about 3400 reference edges
module test_sleep_wake_power_manager;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] q[$];    // expected read data
  logic [15:0] gpio_in, rnd;
  logic [3:0]  rdiv;    // reference divider
  logic [1:0]  htrans;
  logic        irq_any, halt, rext, go, deep, dbg_on, sys_on, rd_dp, rd_dp1;
  logic        wfi, sdeep, dbg_req, sys_req, slp, pwr_on, crst_n, prst_n, rc_on, nmi, wrst, sc1;
  int          mismatches, tests_run, redg, e0, i;
  assign hready = hreadyout;
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;
  swp_power_manager u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .calibrated_khz_reference(rdiv[3]),
    .watch_crystal_clock(1'b0), .crystal_in_use(1'b0), .wfi(wfi), .sleep_deep(sdeep),
    .irq_any(irq_any), .debug_halt(halt), .dbg_pwrup_req(dbg_req), .sys_pwrup_req(sys_req),
    .gpio_in(gpio_in), .routable_external_irq(rext), .core_sleeping(slp),
    .core_power_on(pwr_on), .core_reset_n(crst_n), .periph_reset_n(prst_n),
    .low_freq_rc_oscillator_on(rc_on), .wdog_nmi(nmi), .wdog_reset(wrst), .stimer_irq(),
    .event_timer_tick(), .sc1_clk_en(sc1));
  swp_core_model u_core (.hclk(hclk), .go(go), .deep(deep), .dbg_on(dbg_on),
    .sys_on(sys_on), .wfi(wfi), .sleep_deep(sdeep), .dbg_pwrup_req(dbg_req),
    .sys_pwrup_req(sys_req));
  //////////////////////////////////////////////////////////////////
  // reference clock and its edge count
  always @(posedge hclk) begin
    rdiv <= rdiv + 4'h1;
    if (rdiv == 4'h7) redg <= redg + 1;
  end
  // read result watcher, pops the oldest note
  always @(posedge hclk) begin
    rd_dp  <= hsel & htrans[1] & ~hwrite & hready;
    rd_dp1 <= rd_dp & hready;
    if (rd_dp1) chk(hrdata, q.pop_front());
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer, address phase then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic nap(input logic d);
    deep <= d;
    go   <= 1'b1;
    @(posedge hclk);
    go   <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, about 80000 cycles against 54000 expected
  initial begin
    #640000;
    mismatches++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, irq_any, halt, rext, go, deep, dbg_on, sys_on} = 10'h000;
    {haddr, hwdata, htrans, gpio_in, rdiv, rd_dp, rd_dp1} = 88'h0;
    {redg, mismatches, tests_run, rnd} = {32'h0, 32'h0, 32'h0, 16'h000B};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(swp_pkg::OFS_WDOG, 32'h0);
    rd(swp_pkg::OFS_STCFG, 32'h100);
    rd(swp_pkg::OFS_STATUS, 32'h0);
    rd(8'h28, 32'h0);
    for (i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      xfer(swp_pkg::OFS_CMPA, 1'b1, {rnd, ~rnd});
      rd(swp_pkg::OFS_CMPA, {rnd, ~rnd});
    end
    xfer(swp_pkg::OFS_PERIDIS, 1'b1, 32'hFFFF_FFFF);
    rd(swp_pkg::OFS_PERIDIS, 32'h22);
    chk({31'h0, sc1}, 32'h0);
    xfer(swp_pkg::OFS_PERIDIS, 1'b1, 32'h0);
    rd(swp_pkg::OFS_PERIDIS, 32'h0);
    chk({31'h0, sc1}, 32'h1);
    // idle sleep, woken by an interrupt
    nap(1'b0);
    for (i = 0; i < 10 && slp !== 1'b1; i++) @(posedge hclk);
    rd(swp_pkg::OFS_STATUS, 32'h1);
    chk({30'h0, pwr_on, prst_n}, 32'h3);
    irq_any <= 1'b1;
    for (i = 0; i < 10 && slp !== 1'b0; i++) @(posedge hclk);
    chk({31'h0, slp}, 32'h0);
    irq_any <= 1'b0;
    // deep sleep 0 behind a busy debugger
    dbg_on <= 1'b1;
    sys_on <= 1'b1;
    repeat (6) @(posedge hclk);
    nap(1'b1);
    repeat (20) @(posedge hclk);
    rd(swp_pkg::OFS_STATUS, 32'h2);
    chk({30'h0, pwr_on, prst_n}, 32'h3);
    xfer(swp_pkg::OFS_WAKEREC, 1'b1, 32'h1FF);
    sys_on <= 1'b0;
    for (i = 0; i < 20 && prst_n !== 1'b0; i++) @(posedge hclk);
    chk({30'h0, pwr_on, prst_n}, 32'h2);
    xfer(swp_pkg::OFS_WAKECORE, 1'b1, 32'h1);
    for (i = 0; i < 40 && prst_n !== 1'b1; i++) @(posedge hclk);
    repeat (12) @(posedge hclk);
    rd(swp_pkg::OFS_STATUS, 32'h0);
    rd(swp_pkg::OFS_WAKEREC, 32'h100);
    // deep sleep 1 woken by gpio, deep sleep 2 by the routable irq
    dbg_on <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      xfer(swp_pkg::OFS_CTRL, 1'b1, 32'(m));
      repeat (4) @(posedge hclk);
      xfer(swp_pkg::OFS_WAKEREC, 1'b1, 32'h1FF);
      nap(1'b1);
      for (i = 0; i < 30 && pwr_on !== 1'b0; i++) @(posedge hclk);
      chk({29'h0, pwr_on, crst_n, rc_on}, m ? 32'h0 : 32'h1);
      if (m) rext <= ~rext;
      else gpio_in <= gpio_in ^ 16'h0001;
      for (i = 0; i < 40 && crst_n !== 1'b1; i++) @(posedge hclk);
      chk({30'h0, pwr_on, rc_on}, 32'h3);
      rd(swp_pkg::OFS_WAKEREC, m ? 32'h4 : 32'h1);
    end
    // watchdog restart, halt pause, warning and expiry
    xfer(swp_pkg::OFS_WDOG, 1'b1, 32'h1);
    e0 = redg;
    while (redg < e0 + 1000) @(posedge hclk);
    xfer(swp_pkg::OFS_WDOG, 1'b1, 32'h3);
    e0 = redg;
    while (redg < e0 + 500) @(posedge hclk);
    halt <= 1'b1;
    while (redg < e0 + 800) @(posedge hclk);
    halt <= 1'b0;
    for (i = 0; i < 40000 && nmi !== 1'b1; i++) @(posedge hclk);
    chk({31'h0, (redg - e0 >= 2090 && redg - e0 <= 2094)}, 32'h1);
    e0 = redg;
    for (i = 0; i < 8000 && wrst !== 1'b1; i++) @(posedge hclk);
    chk({31'h0, (redg - e0 >= 254 && redg - e0 <= 258)}, 32'h1);
    xfer(swp_pkg::OFS_WDOG, 1'b1, 32'h0);
    repeat (4) @(posedge hclk);
    end_sim();
  end
endmodule // test_sleep_wake_power_manager
